// File: hdl/mta_core.sv
// Digital core of a seven-channel temperature monitor behind an SMBus slave.
// Assumes a byte-level SMBus slave front end: it decodes transactions into
// the strobes below, and carries arbitration on the wire for alert response.
// Functional notes
// - Four byte transactions at one slave address
// - Receive byte returns register at stored pointer
// - Channel 1 eleven bits, others eight
// - High byte clamps 0 to 127
// - Fraction in top three bits of extended
// - Extended read freezes high byte until read or 37ms pass
// - Open diode stores FFh, no alarms
// - Fault detect takes 4ms, then next channel
// - Seven alert and four overtemp limits
// - Alert on reading above unmasked limit
// - Alert clears by status read or won response
// - Alert never pauses conversions
// - Alert pin only pulls low
// - Alert response sends address, lower wins
// - Overtemp output with 4 degree hysteresis
// - Eight-bit command pointer resets zero
// - Config1 bit 7 selects standby
// - Config1 bit 6 soft reset, self-clears
// - Config1 bit 5 disables timeout; resets 0Ch
// - Config1 bits 3,2 compensation enables
// - Config2 bits 6:0 mask alerts
// - Config3 bits 5,4,3,0 mask overtemp
// - Sequence 1,2,3,local,4,5,6
`timescale 1ns/100ps
`include "mta_defines.svh"
`default_nettype none

module mta_core #(
   parameter int FREEZE_CYC = `MTA_FREEZE_CYC,
   parameter int FAULT_CYC = `MTA_FAULT_CYC
) (
   input wire logic I_CLOCK,
   input wire logic I_RESET_N,
   input wire logic I_CMD_WR,
   input wire logic [7:0] I_CMD,
   input wire logic I_DATA_WR,
   input wire logic [7:0] I_DATA,
   input wire logic I_READ,
   output logic [7:0] O_RDATA,
   input wire logic I_ARA_READ,
   input wire logic I_ARA_WON,
   output logic O_ARA_RESPOND,
   input wire logic I_CONV_START,
   output logic O_CONV_REQ,
   output logic [2:0] O_CONV_CHAN,
   input wire logic I_CONV_DONE,
   input wire logic I_DIODE_OPEN,
   input wire logic signed [11:0] I_CONV_RESULT,
   output logic O_ALERT_N_OUT,
   output logic O_ALERT_N_OE,
   output logic O_OVERHEAT_SHUTDOWN_OUT,
   output logic O_TIMEOUT_EN,
   output logic O_RES_CANCEL_EN,
   output logic O_BETA_COMP_EN,
   output logic O_STANDBY
);

   // Channel index: 0 local, 1..6 remote
   logic [7:0] cmd_reg;
   logic [7:0] cfg1_reg;
   logic [7:0] cfg2_reg;
   logic [7:0] cfg3_reg;
   logic [7:0] temp_reg [0:6];
   logic [2:0] frac_reg;
   logic [7:0] alim_reg [0:6];
   logic [7:0] olim_reg [0:3];
   logic [6:0] alert_stat_reg;
   logic [6:0] over_stat_reg;
   logic [6:0] fault_stat_reg;
   logic over_active_reg;
   logic freeze_reg;
   logic [31:0] freeze_cnt_reg;
   logic [31:0] fault_cnt_reg;
   logic [2:0] seq_pos_reg;
   logic [7:0] rdata_reg;
   mta_pkg::mta_seq_t seq_reg;
   logic soft_rst;
   logic rst;
   logic [2:0] chan;
   logic [7:0] clamped;
   logic [7:0] store_val;
   logic conv_end;
   logic [7:0] rd_val;
   logic [1:0] oidx;
   logic is_over_chan;

   assign soft_rst = I_DATA_WR && (cmd_reg == `MTA_PTR_CFG1) && I_DATA[`MTA_CFG1_SWRST];
   assign rst = !I_RESET_N || soft_rst;

   // Sequence order 1,2,3,local,4,5,6
   always_comb begin
      case (seq_pos_reg)
         3'd0: chan = 3'd1;
         3'd1: chan = 3'd2;
         3'd2: chan = 3'd3;
         3'd3: chan = 3'd0;
         3'd4: chan = 3'd4;
         3'd5: chan = 3'd5;
         default: chan = 3'd6;
      endcase
   end

   always_comb begin
      case (chan)
         3'd1: begin
            oidx = 2'd0;
            is_over_chan = 1'b1;
         end
         3'd4: begin
            oidx = 2'd1;
            is_over_chan = 1'b1;
         end
         3'd5: begin
            oidx = 2'd2;
            is_over_chan = 1'b1;
         end
         3'd6: begin
            oidx = 2'd3;
            is_over_chan = 1'b1;
         end
         default: begin
            oidx = 2'd0;
            is_over_chan = 1'b0;
         end
      endcase
   end

   // Result is signed degrees with three fraction bits
   always_comb begin
      if (I_CONV_RESULT < 0) begin
         clamped = 8'h00;
      end else if (I_CONV_RESULT[11:3] > 9'sd127) begin
         clamped = `MTA_TEMP_MAX;
      end else begin
         clamped = {1'b0, I_CONV_RESULT[9:3]};
      end
      store_val = I_DIODE_OPEN ? `MTA_TEMP_FAULT : clamped;
   end

   assign O_CONV_REQ = (seq_reg == mta_pkg::MTA_SEQ_IDLE) && !cfg1_reg[`MTA_CFG1_STOP];
   assign O_CONV_CHAN = chan;
   assign O_STANDBY = cfg1_reg[`MTA_CFG1_STOP];
   assign conv_end = (seq_reg == mta_pkg::MTA_SEQ_STORE);

   // Sequencer; alert state has no say in it, so alerts never pause conversions
   always_ff @(posedge I_CLOCK) begin
      if (rst) begin
         seq_reg <= mta_pkg::MTA_SEQ_IDLE;
         seq_pos_reg <= 3'd0;
         fault_cnt_reg <= 32'd0;
      end else begin
         case (seq_reg)
            mta_pkg::MTA_SEQ_IDLE: begin
               fault_cnt_reg <= 32'd0;
               if (O_CONV_REQ && I_CONV_START) begin
                  seq_reg <= mta_pkg::MTA_SEQ_WAIT;
               end
            end
            mta_pkg::MTA_SEQ_WAIT: begin
               fault_cnt_reg <= fault_cnt_reg + 32'd1;
               if (cfg1_reg[`MTA_CFG1_STOP]) begin
                  seq_reg <= mta_pkg::MTA_SEQ_IDLE; // Aborted: no update
               end else if (I_CONV_DONE && (!I_DIODE_OPEN || fault_cnt_reg >= FAULT_CYC)) begin
                  seq_reg <= mta_pkg::MTA_SEQ_STORE;
               end
            end
            mta_pkg::MTA_SEQ_STORE: begin
               seq_reg <= mta_pkg::MTA_SEQ_IDLE;
               seq_pos_reg <= (seq_pos_reg == 3'd6) ? 3'd0 : seq_pos_reg + 3'd1;
            end
            default: seq_reg <= mta_pkg::MTA_SEQ_IDLE;
         endcase
      end
   end

   // Latched result captured on entering store
   logic [7:0] res_val_reg;
   logic [2:0] res_frac_reg;
   logic res_open_reg;
   always_ff @(posedge I_CLOCK) begin
      if (rst) begin
         res_val_reg <= 8'h00;
         res_frac_reg <= 3'd0;
         res_open_reg <= 1'b0;
      end else if (seq_reg == mta_pkg::MTA_SEQ_WAIT && I_CONV_DONE) begin
         res_val_reg <= store_val;
         res_frac_reg <= (I_DIODE_OPEN || I_CONV_RESULT < 0) ? 3'd0 : I_CONV_RESULT[2:0];
         res_open_reg <= I_DIODE_OPEN;
      end
   end

   // Extended read freezes channel 1 high byte
   always_ff @(posedge I_CLOCK) begin
      if (rst) begin
         freeze_reg <= 1'b0;
         freeze_cnt_reg <= 32'd0;
      end else if (I_READ && cmd_reg == `MTA_PTR_EXT) begin
         freeze_reg <= 1'b1;
         freeze_cnt_reg <= 32'd0;
      end else if (freeze_reg) begin
         freeze_cnt_reg <= freeze_cnt_reg + 32'd1;
         if ((I_READ && cmd_reg == `MTA_PTR_REM_BASE + 8'd1) || freeze_cnt_reg >= FREEZE_CYC - 1) begin
            freeze_reg <= 1'b0;
         end
      end
   end

   // Temperature data and compare per channel
   generate
      for (genvar g = 0; g < 7; g++) begin : g_chan
         always_ff @(posedge I_CLOCK) begin
            if (rst) begin
               temp_reg[g] <= 8'h00;
               fault_stat_reg[g] <= 1'b0;
            end else if (conv_end && chan == 3'(g)) begin
               if (!(g == 1 && freeze_reg)) begin
                  temp_reg[g] <= res_val_reg;
               end
               fault_stat_reg[g] <= res_open_reg && (g != 0);
            end
         end
      end
   endgenerate

   always_ff @(posedge I_CLOCK) begin
      if (rst) begin
         frac_reg <= 3'd0;
      end else if (conv_end && chan == 3'd1 && !freeze_reg) begin
         frac_reg <= res_frac_reg;
      end
   end

   // Alert status: set at conversion end wins over clear
   logic [6:0] alert_set;
   always_comb begin
      alert_set = 7'h00;
      if (conv_end && !res_open_reg && res_val_reg > alim_reg[chan]) begin
         alert_set[chan] = 1'b1;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (rst) begin
         alert_stat_reg <= 7'h00;
      end else if ((I_READ && cmd_reg == `MTA_PTR_STAT1) || (I_ARA_READ && I_ARA_WON)) begin
         alert_stat_reg <= alert_set;
      end else begin
         alert_stat_reg <= alert_stat_reg | alert_set;
      end
   end

   // Mask bit 6 is local (index 0), bits 5:0 remote 6..1
   logic [6:0] mask_by_chan;
   assign mask_by_chan = {cfg2_reg[5:0], cfg2_reg[`MTA_CFG2_LOCAL]};
   assign O_ARA_RESPOND = |(alert_stat_reg & ~mask_by_chan);
   assign O_ALERT_N_OUT = 1'b0;
   assign O_ALERT_N_OE = O_ARA_RESPOND;

   // Over-temperature with hysteresis
   always_ff @(posedge I_CLOCK) begin
      if (rst) begin
         over_stat_reg <= 7'h00;
      end else if (conv_end && is_over_chan) begin
         if (res_open_reg) begin
            over_stat_reg[chan] <= 1'b0;
         end else if (res_val_reg > olim_reg[oidx]) begin
            over_stat_reg[chan] <= 1'b1;
         end else if ({1'b0, res_val_reg} + 9'(`MTA_HYST) < {1'b0, olim_reg[oidx]}) begin
            over_stat_reg[chan] <= 1'b0;
         end
      end
   end

   logic [6:0] over_mask;
   assign over_mask = {cfg3_reg[5], cfg3_reg[4], cfg3_reg[3], 2'b00, cfg3_reg[0], 1'b0};
   always_ff @(posedge I_CLOCK) begin
      if (rst) begin
         over_active_reg <= 1'b0;
      end else begin
         over_active_reg <= |(over_stat_reg & ~over_mask);
      end
   end
   assign O_OVERHEAT_SHUTDOWN_OUT = over_active_reg;

   // Command pointer and register writes
   always_ff @(posedge I_CLOCK) begin
      if (rst) begin
         cmd_reg <= `MTA_PTR_RESET;
      end else if (I_CMD_WR) begin
         cmd_reg <= I_CMD;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (rst) begin
         cfg1_reg <= `MTA_CFG1_RESET;
         cfg2_reg <= `MTA_CFG2_RESET;
         cfg3_reg <= `MTA_CFG3_RESET;
      end else if (I_DATA_WR) begin
         case (cmd_reg)
            `MTA_PTR_CFG1: cfg1_reg <= I_DATA & `MTA_CFG1_WMASK & 8'hBF;
            `MTA_PTR_CFG2: cfg2_reg <= I_DATA & `MTA_CFG2_WMASK;
            `MTA_PTR_CFG3: cfg3_reg <= I_DATA & `MTA_CFG3_WMASK;
            default: cfg1_reg <= cfg1_reg;
         endcase
      end
   end

   generate
      for (genvar a = 0; a < 7; a++) begin : g_alim
         always_ff @(posedge I_CLOCK) begin
            if (rst) begin
               alim_reg[a] <= (a == 0) ? `MTA_ALIM_LOCAL_RESET : `MTA_ALIM_REM_RESET;
            end else if (I_DATA_WR && cmd_reg == ((a == 0) ? `MTA_PTR_ALIM_LOCAL
                                             : `MTA_PTR_ALIM_BASE + 8'(a))) begin
               alim_reg[a] <= I_DATA;
            end
         end
      end
      for (genvar o = 0; o < 4; o++) begin : g_olim
         localparam logic [7:0] OCH = (o == 0) ? 8'd1 : 8'(o + 3);
         always_ff @(posedge I_CLOCK) begin
            if (rst) begin
               olim_reg[o] <= (o == 0) ? `MTA_OLIM1_RESET :
                              (o == 1) ? `MTA_OLIM4_RESET : `MTA_OLIM56_RESET;
            end else if (I_DATA_WR && cmd_reg == `MTA_PTR_OLIM_BASE + OCH) begin
               olim_reg[o] <= I_DATA;
            end
         end
      end
   endgenerate

   // Read mux; unmapped pointers read zero
   always_comb begin
      rd_val = 8'h00;
      case (cmd_reg)
         `MTA_PTR_LOCAL: rd_val = temp_reg[0];
         8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06: rd_val = temp_reg[cmd_reg[2:0]];
         `MTA_PTR_EXT: rd_val = {frac_reg, 5'b00000};
         `MTA_PTR_ID: rd_val = `MTA_ID_VALUE; // Arbitrary identity value
         `MTA_PTR_CFG1: rd_val = cfg1_reg;
         `MTA_PTR_CFG2: rd_val = cfg2_reg;
         `MTA_PTR_CFG3: rd_val = cfg3_reg;
         `MTA_PTR_STAT1: rd_val = {1'b0, alert_stat_reg[0], alert_stat_reg[1], alert_stat_reg[2],
                                   alert_stat_reg[3], alert_stat_reg[4], alert_stat_reg[5],
                                   alert_stat_reg[6]} >> 0;
         `MTA_PTR_STAT2: rd_val = {1'b0, over_stat_reg};
         `MTA_PTR_STAT3: rd_val = {1'b0, fault_stat_reg};
         `MTA_PTR_ALIM_LOCAL: rd_val = alim_reg[0];
         8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16: rd_val = alim_reg[cmd_reg[2:0]];
         8'h21: rd_val = olim_reg[0];
         8'h24: rd_val = olim_reg[1];
         8'h25: rd_val = olim_reg[2];
         8'h26: rd_val = olim_reg[3];
         default: rd_val = 8'h00;
      endcase
   end

   // Data presented one cycle after any pointer change
   always_ff @(posedge I_CLOCK) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rd_val;
      end
   end
   assign O_RDATA = rdata_reg;

   assign O_TIMEOUT_EN = !cfg1_reg[`MTA_CFG1_TODIS];
   assign O_RES_CANCEL_EN = cfg1_reg[`MTA_CFG1_RCANC];
   assign O_BETA_COMP_EN = cfg1_reg[`MTA_CFG1_BETA];

endmodule // mta_core

`default_nettype wire

// File: hdl/mta_defines.svh
// Constants for the temperature monitor digital core: register pointers,
// reset values, field positions and timing counts. Clock assumed 40 MHz.
`ifndef MTA_DEFINES_SVH
`define MTA_DEFINES_SVH

`define MTA_CLK_HZ 40000000
`define MTA_FREEZE_MS 37
`define MTA_FREEZE_CYC ((`MTA_CLK_HZ / 1000) * `MTA_FREEZE_MS)
`define MTA_FAULT_MS 4
`define MTA_FAULT_CYC ((`MTA_CLK_HZ / 1000) * `MTA_FAULT_MS)
`define MTA_HYST 8'h04

`define MTA_PTR_RESET 8'h00
`define MTA_PTR_LOCAL 8'h07
`define MTA_PTR_REM_BASE 8'h00
`define MTA_PTR_EXT 8'h09
`define MTA_PTR_ID 8'h0A
`define MTA_PTR_CFG1 8'h41
`define MTA_PTR_CFG2 8'h42
`define MTA_PTR_CFG3 8'h43
`define MTA_PTR_STAT1 8'h44
`define MTA_PTR_STAT2 8'h45
`define MTA_PTR_STAT3 8'h46
`define MTA_PTR_ALIM_BASE 8'h10
`define MTA_PTR_ALIM_LOCAL 8'h17
`define MTA_PTR_OLIM_BASE 8'h20

`define MTA_CFG1_RESET 8'h0C
`define MTA_CFG1_WMASK 8'hEC
`define MTA_CFG2_RESET 8'h00
`define MTA_CFG2_WMASK 8'h7F
`define MTA_CFG3_RESET 8'h00
`define MTA_CFG3_WMASK 8'h39
`define MTA_CFG1_STOP 7
`define MTA_CFG1_SWRST 6
`define MTA_CFG1_TODIS 5
`define MTA_CFG1_RCANC 3
`define MTA_CFG1_BETA 2
`define MTA_CFG2_LOCAL 6

`define MTA_ALIM_LOCAL_RESET 8'h5A
`define MTA_ALIM_REM_RESET 8'h64
`define MTA_OLIM1_RESET 8'h6E
`define MTA_OLIM4_RESET 8'h7F
`define MTA_OLIM56_RESET 8'h5A

`define MTA_TEMP_MAX 8'h7F
`define MTA_TEMP_FAULT 8'hFF
`define MTA_ID_VALUE 8'h5C

`endif

// File: hdl/mta_pkg.sv
// Types for the temperature monitor digital core.
// Assumes mta_defines.svh is compiled alongside.
package mta_pkg;
   typedef enum logic [1:0] {
      MTA_SEQ_IDLE,
      MTA_SEQ_WAIT,
      MTA_SEQ_STORE
   } mta_seq_t;
endpackage

// File: testbench/mta_checker.sv
// Concurrent checks on the temperature monitor core ports.
// Bound into mta_core; sees its ports only, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module mta_checker (
   input wire logic I_CLOCK,
   input wire logic I_RESET_N,
   input wire logic I_CMD_WR,
   input wire logic [7:0] I_CMD,
   input wire logic I_DATA_WR,
   input wire logic [7:0] I_DATA,
   input wire logic I_READ,
   input wire logic I_ARA_READ,
   input wire logic I_ARA_WON,
   input wire logic I_CONV_START,
   input wire logic I_CONV_DONE,
   input wire logic O_CONV_REQ,
   input wire logic [2:0] O_CONV_CHAN,
   input wire logic O_ALERT_N_OUT,
   input wire logic O_ALERT_N_OE,
   input wire logic O_OVERHEAT_SHUTDOWN_OUT,
   input wire logic O_TIMEOUT_EN,
   input wire logic O_RES_CANCEL_EN,
   input wire logic O_BETA_COMP_EN,
   input wire logic O_STANDBY
);
   // Next channel in scan order, indexed by current channel
   localparam logic [20:0] NXT = {3'h1, 3'h6, 3'h5, 3'h0, 3'h3, 3'h2, 3'h4};
   logic [7:0] ptr_q;
   logic [2:0] last_q;
   logic started_q;
   logic cfg1_wr;
   assign cfg1_wr = I_DATA_WR && ptr_q == 8'h41;
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N || (cfg1_wr && I_DATA[6])) ptr_q <= 8'h00;
      else if (I_CMD_WR) ptr_q <= I_CMD;
   end
   // Config1 writes may restart the scan, so order is relearned
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N || cfg1_wr) started_q <= 1'b0;
      else if (I_CONV_START) started_q <= 1'b1;
   end
   always_ff @(posedge I_CLOCK) begin
      if (I_CONV_START) last_q <= O_CONV_CHAN;
   end
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!I_RESET_N);
   a_alert_pull_only: assert property (O_ALERT_N_OE |-> !O_ALERT_N_OUT)
      else $error("alert pin driven high");
   a_standby_idle: assert property (O_STANDBY |-> !O_CONV_REQ)
      else $error("conversion requested in standby");
   a_cfg1_apply: assert property (cfg1_wr && !I_DATA[6] |=>
      O_STANDBY == $past(I_DATA[7]) && O_TIMEOUT_EN == !$past(I_DATA[5]) &&
      O_RES_CANCEL_EN == $past(I_DATA[3]) && O_BETA_COMP_EN == $past(I_DATA[2]))
      else $error("config outputs do not follow write");
   a_soft_reset: assert property (cfg1_wr && I_DATA[6] |=> O_TIMEOUT_EN &&
      O_RES_CANCEL_EN && O_BETA_COMP_EN && !O_STANDBY && !O_ALERT_N_OE)
      else $error("soft reset did not restore outputs");
   a_status_clear: assert property (I_READ && ptr_q == 8'h44 && !$past(I_CONV_DONE)
      |=> !O_ALERT_N_OE) else $error("status read left alert asserted");
   a_ara_clear: assert property (I_ARA_READ && I_ARA_WON && !$past(I_CONV_DONE)
      |=> !O_ALERT_N_OE) else $error("won alert response left alert asserted");
   a_ara_lose: assert property (I_ARA_READ && !I_ARA_WON && !I_READ && !I_DATA_WR
      && O_ALERT_N_OE |=> O_ALERT_N_OE) else $error("lost alert response released alert");
   // Unmasking a pending status raises the alert too
   a_alert_cause: assert property ($rose(O_ALERT_N_OE) |-> $past(I_CONV_DONE) ||
      $past(I_CONV_DONE, 2) || $past(I_CONV_DONE, 3) || $past(I_DATA_WR && ptr_q == 8'h42))
      else $error("alert rose without result");
   a_overheat_cause: assert property ($rose(O_OVERHEAT_SHUTDOWN_OUT) |->
      $past(I_CONV_DONE) || $past(I_CONV_DONE, 2) || $past(I_CONV_DONE, 3) ||
      $past(I_DATA_WR && ptr_q == 8'h43, 2))
      else $error("overheat rose without result");
   a_chan_order: assert property (I_CONV_START && started_q |->
      O_CONV_CHAN == NXT[last_q * 3 +: 3]) else $error("channel out of scan order");
   c_alert: cover property ($rose(O_ALERT_N_OE));
   c_overheat: cover property ($rose(O_OVERHEAT_SHUTDOWN_OUT));
   c_ara_won: cover property (I_ARA_READ && I_ARA_WON && O_ALERT_N_OE);
endmodule // mta_checker
bind mta_core mta_checker u_mta_checker (.I_CLOCK, .I_RESET_N, .I_CMD_WR, .I_CMD, .I_DATA_WR,
   .I_DATA, .I_READ, .I_ARA_READ, .I_ARA_WON, .I_CONV_START, .I_CONV_DONE, .O_CONV_REQ,
   .O_CONV_CHAN, .O_ALERT_N_OUT, .O_ALERT_N_OE, .O_OVERHEAT_SHUTDOWN_OUT, .O_TIMEOUT_EN,
   .O_RES_CANCEL_EN, .O_BETA_COMP_EN, .O_STANDBY);
`default_nettype wire

// File: testbench/mta_core_tb.sv
// Self-checking bench for mta_core: host model on the bus side,
// bench-driven converter handshake, short freeze and fault counts.
`timescale 1ns/100ps
`default_nettype none
module mta_core_tb;
   localparam int FZ = 100;
   localparam int FC = 20;
   localparam logic [7:0] PT [10] = '{8'h42, 8'h43, 8'h17, 8'h11, 8'h21, 8'h24, 8'h25, 8'h26,
      8'h07, 8'h41};
   localparam logic [7:0] PV [10] = '{8'h00, 8'h00, 8'h5A, 8'h64, 8'h6E, 8'h7F, 8'h5A, 8'h5A,
      8'h00, 8'h0C};
   localparam logic [11:0] HT [3] = '{12'h188, 12'h160, 12'h158};
   localparam logic [2:0] SEQ [7] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h4, 3'h5, 3'h6};
   logic I_CLOCK = 1'b0;
   logic I_RESET_N = 1'b0;
   logic I_CMD_WR, I_DATA_WR, I_READ, I_ARA_READ, I_ARA_WON;
   logic [7:0] I_CMD, I_DATA, O_RDATA;
   logic I_CONV_START = 1'b0;
   logic I_CONV_DONE = 1'b0;
   logic I_DIODE_OPEN = 1'b0;
   logic signed [11:0] I_CONV_RESULT = 12'h000;
   logic O_ARA_RESPOND, O_CONV_REQ, O_ALERT_N_OUT, O_ALERT_N_OE, O_OVERHEAT_SHUTDOWN_OUT;
   logic O_TIMEOUT_EN, O_RES_CANCEL_EN, O_BETA_COMP_EN, O_STANDBY;
   logic [2:0] O_CONV_CHAN;
   logic [11:0] temps [7];
   logic [6:0] open_ch = 7'h00;
   logic [15:0] lfsr = 16'h8536;
   logic [7:0] v;
   logic [7:0] held;
   int bad_count = 0;
   int n_compared = 0;
   int idx = 0;
   always #12.5 I_CLOCK = ~I_CLOCK;
   mta_core #(.FREEZE_CYC(FZ), .FAULT_CYC(FC)) u_mta_core (.I_CLOCK, .I_RESET_N, .I_CMD_WR,
      .I_CMD, .I_DATA_WR, .I_DATA, .I_READ, .O_RDATA, .I_ARA_READ, .I_ARA_WON, .O_ARA_RESPOND,
      .I_CONV_START, .O_CONV_REQ, .O_CONV_CHAN, .I_CONV_DONE, .I_DIODE_OPEN, .I_CONV_RESULT,
      .O_ALERT_N_OUT, .O_ALERT_N_OE, .O_OVERHEAT_SHUTDOWN_OUT, .O_TIMEOUT_EN, .O_RES_CANCEL_EN,
      .O_BETA_COMP_EN, .O_STANDBY);
   mta_host_model u_mta_host_model (.i_clock(I_CLOCK), .i_rdata(O_RDATA), .o_cmd_wr(I_CMD_WR),
      .o_cmd(I_CMD), .o_data_wr(I_DATA_WR), .o_data(I_DATA), .o_read(I_READ),
      .o_ara_read(I_ARA_READ), .o_ara_won(I_ARA_WON));
   function automatic logic [15:0] step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // High byte of a result: clamped to 0..127
   function automatic logic [7:0] exp_hi(input logic [11:0] r);
      return r[11] ? 8'h00 : (r[10] ? 8'h7F : {1'b0, r[9:3]});
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      n_compared++;
      if (got !== want) begin
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
         bad_count++;
      end
   endtask
   task automatic rdt(input logic [7:0] p, input logic [7:0] want);
      logic [7:0] d;
      u_mta_host_model.rd(p, d);
      chk(d, want);
   endtask
   // One converter handshake; open channels answer only after the fault wait
   task automatic conv;
      logic [2:0] ch;
      int i;
      i = 0;
      while (O_CONV_REQ !== 1'b1 && i < 40) begin
         @(posedge I_CLOCK);
         #1;
         i++;
      end
      chk({O_CONV_REQ, 4'h0, O_CONV_CHAN}, {1'b1, 4'h0, SEQ[idx]});
      ch = O_CONV_CHAN;
      idx = (idx + 1) % 7;
      I_CONV_START = 1'b1;
      @(posedge I_CLOCK);
      #1;
      I_CONV_START = 1'b0;
      repeat (open_ch[ch] ? FC + 2 : 3) @(posedge I_CLOCK);
      #1;
      I_CONV_DONE = 1'b1;
      I_DIODE_OPEN = open_ch[ch];
      I_CONV_RESULT = temps[ch];
      @(posedge I_CLOCK);
      #1;
      I_CONV_DONE = 1'b0;
      I_DIODE_OPEN = ~I_DIODE_OPEN;
      I_CONV_RESULT = ~I_CONV_RESULT;
      repeat (3) @(posedge I_CLOCK);
      #1;
   endtask
   task automatic sweep;
      repeat (7) conv;
   endtask
   task automatic stop_test;
      if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge I_CLOCK);
      bad_count++;
      stop_test;
   end
   initial begin
      for (int c = 0; c < 7; c++) temps[c] = 12'h000;
      repeat (5) @(posedge I_CLOCK);
      #1;
      I_RESET_N = 1'b1;
      chk({2'h0, O_STANDBY, O_TIMEOUT_EN, O_RES_CANCEL_EN, O_BETA_COMP_EN, O_ALERT_N_OE,
         O_OVERHEAT_SHUTDOWN_OUT}, 8'h1C);
      for (int k = 0; k < 10; k++) rdt(PT[k], PV[k]);
      u_mta_host_model.recv(v);
      chk(v, 8'h0C);
      u_mta_host_model.wr(8'h07, 8'hAA);
      rdt(8'h07, 8'h00);
      repeat (4) begin
         lfsr = step(lfsr);
         v = lfsr[7:0] & 8'h3F;
         u_mta_host_model.wr(8'h41, v);
         chk({5'h0, O_TIMEOUT_EN, O_RES_CANCEL_EN, O_BETA_COMP_EN}, {5'h0, ~v[5], v[3], v[2]});
         rdt(8'h41, v & 8'hEC);
         u_mta_host_model.wr(8'h42, lfsr[15:8]);
         rdt(8'h42, lfsr[15:8] & 8'h7F);
         u_mta_host_model.wr(8'h43, lfsr[15:8]);
         rdt(8'h43, lfsr[15:8] & 8'h39);
      end
      u_mta_host_model.wr(8'h41, 8'h0C);
      u_mta_host_model.wr(8'h42, 8'h7F);
      u_mta_host_model.wr(8'h43, 8'h00);
      for (int c = 0; c < 7; c++) begin
         lfsr = step(lfsr);
         temps[c] = {3'h0, lfsr[8:0]};
      end
      temps[2] = 12'h7FF;
      temps[3] = 12'hF00;
      sweep;
      chk({7'h0, O_ALERT_N_OE}, 8'h00);
      u_mta_host_model.rd(8'h09, v);
      chk(v & 8'hE0, {temps[1][2:0], 5'h00});
      for (int p = 1; p < 8; p++) rdt(8'(p), exp_hi(temps[p % 7]));
      // Freeze after extended read, released by high read or by time
      u_mta_host_model.rd(8'h09, v);
      held = exp_hi(temps[1]);
      temps[1] = temps[1] + 12'h040;
      sweep;
      rdt(8'h01, held);
      sweep;
      rdt(8'h01, exp_hi(temps[1]));
      u_mta_host_model.rd(8'h09, v);
      temps[1] = temps[1] + 12'h040;
      repeat (FZ + 10) @(posedge I_CLOCK);
      #1;
      sweep;
      rdt(8'h01, exp_hi(temps[1]));
      u_mta_host_model.wr(8'h42, 8'h00);
      u_mta_host_model.wr(8'h12, 8'h10);
      temps[2] = 12'h100;
      sweep;
      chk({6'h0, O_ALERT_N_OE, O_ARA_RESPOND}, 8'h03);
      u_mta_host_model.rd(8'h44, v);
      chk(v, 8'h10);
      chk({7'h0, O_ALERT_N_OE}, 8'h00);
      sweep;
      u_mta_host_model.ara(1'b0);
      chk({7'h0, O_ALERT_N_OE}, 8'h01);
      u_mta_host_model.ara(1'b1);
      chk({7'h0, O_ALERT_N_OE}, 8'h00);
      u_mta_host_model.wr(8'h42, 8'h7F);
      sweep;
      chk({7'h0, O_ALERT_N_OE}, 8'h00);
      temps[2] = 12'h040;
      // Masked status still pending; clear it before unmasking
      u_mta_host_model.rd(8'h44, v);
      chk(v, 8'h10);
      u_mta_host_model.wr(8'h42, 8'h00);
      u_mta_host_model.wr(8'h21, 8'h30);
      for (int k = 0; k < 3; k++) begin
         temps[1] = HT[k];
         sweep;
         chk({7'h0, O_OVERHEAT_SHUTDOWN_OUT}, {7'h0, k < 2});
      end
      u_mta_host_model.wr(8'h43, 8'h01);
      temps[1] = HT[0];
      sweep;
      chk({7'h0, O_OVERHEAT_SHUTDOWN_OUT}, 8'h00);
      temps[1] = 12'h040;
      sweep;
      u_mta_host_model.wr(8'h43, 8'h00);
      open_ch = 7'h0A;
      sweep;
      rdt(8'h01, 8'hFF);
      rdt(8'h03, 8'hFF);
      rdt(8'h46, 8'h0A);
      chk({6'h0, O_ALERT_N_OE, O_OVERHEAT_SHUTDOWN_OUT}, 8'h00);
      open_ch = 7'h00;
      u_mta_host_model.wr(8'h41, 8'h4C);
      rdt(8'h21, 8'h6E);
      rdt(8'h41, 8'h0C);
      u_mta_host_model.wr(8'h41, 8'h8C);
      chk({6'h0, O_STANDBY, O_CONV_REQ}, 8'h02);
      u_mta_host_model.wr(8'h41, 8'h0C);
      chk({6'h0, O_STANDBY, O_CONV_REQ}, 8'h01);
      stop_test;
   end
endmodule // mta_core_tb
`default_nettype wire

// File: testbench/mta_host_model.sv
// Host-side model issuing byte-level SMBus transactions to the core.
// Tasks are called by the bench; each starts one edge after the call.
`timescale 1ns/100ps
`default_nettype none
module mta_host_model (
   input wire logic i_clock,
   input wire logic [7:0] i_rdata,
   output logic o_cmd_wr,
   output logic [7:0] o_cmd,
   output logic o_data_wr,
   output logic [7:0] o_data,
   output logic o_read,
   output logic o_ara_read,
   output logic o_ara_won
);
   initial begin
      o_cmd_wr = 1'b0;
      o_cmd = 8'h00;
      o_data_wr = 1'b0;
      o_data = 8'h00;
      o_read = 1'b0;
      o_ara_read = 1'b0;
      o_ara_won = 1'b0;
   end
   // Command byte phase; lines carry garbage once released
   task automatic set_ptr(input logic [7:0] p);
      @(posedge i_clock);
      #1;
      o_cmd_wr = 1'b1;
      o_cmd = p;
      @(posedge i_clock);
      #1;
      o_cmd_wr = 1'b0;
      o_cmd = ~p;
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      set_ptr(p);
      o_data_wr = 1'b1;
      o_data = d;
      @(posedge i_clock);
      #1;
      o_data_wr = 1'b0;
      o_data = ~d;
   endtask
   // Receive byte: uses whatever pointer is stored
   task automatic recv(output logic [7:0] d);
      @(posedge i_clock);
      #1;
      d = i_rdata;
      o_read = 1'b1;
      @(posedge i_clock);
      #1;
      o_read = 1'b0;
   endtask
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      set_ptr(p);
      recv(d);
   endtask
   task automatic ara(input logic won);
      @(posedge i_clock);
      #1;
      o_ara_read = 1'b1;
      o_ara_won = won;
      @(posedge i_clock);
      #1;
      o_ara_read = 1'b0;
      o_ara_won = ~won;
   endtask
endmodule // mta_host_model
`default_nettype wire
